//--- common/lst_pkg.sv
// constants shared by the link self-test status and control block
package lst_pkg;

	localparam int          ADDR_W     = 12;
	localparam int          NPORT      = 8;
	localparam int          SYM_W      = 9;
	localparam logic [7:0]  PORT_MASK  = 8'hfd;

	// register indices; byte address is four times the index
	localparam logic [9:0]  CTRL_IDX   = 10'h380;
	localparam logic [9:0]  STAT_IDX   = 10'h394;
	localparam logic [9:0]  ERR_IDX    = 10'h395;
	localparam logic [9:0]  START_IDX  = 10'h398;
	localparam logic [9:0]  ISTS_IDX   = 10'h3a0;
	localparam logic [9:0]  IMSK_IDX   = 10'h3a1;

	// control register fields
	localparam int          KIND_LSB   = 28;
	localparam int          SLOT3_BIT  = 31;
	localparam int          MODE_BIT   = 0;
	localparam logic [3:0]  KIND_RST   = 4'h5;
	localparam logic        MODE_RST   = 1'b0;

	// status, error, start, interrupt reset values
	localparam logic [7:0]  STAT_RST   = 8'h00;
	localparam logic [7:0]  ERR_RST    = 8'h00;
	localparam logic [7:0]  START_RST  = 8'h00;
	localparam logic [15:0] ISTS_RST   = 16'h0000;
	localparam logic [15:0] IMSK_RST   = 16'h0000;

	// test run length in clock cycles
	localparam int          TEST_LEN   = 256;

	typedef enum logic {
		LST_IDLE = 1'b0,
		LST_RUN  = 1'b1
	} lst_state_t;

	// fixed-mode byte for each pattern slot
	function automatic logic [7:0] lst_fixed_byte(input logic [1:0] slot);
		case (slot)
			2'h0:    lst_fixed_byte = 8'hbc;
			2'h1:    lst_fixed_byte = 8'h4a;
			2'h2:    lst_fixed_byte = 8'hbc;
			default: lst_fixed_byte = 8'hb5;
		endcase
	endfunction

endpackage

//--- verif/lst_link_partner.sv
// link partner model sending the fixed test pattern on each launched port
module lst_link_partner #(
	parameter int TEST_LEN = 8
) (
	input  wire logic        clk,
	input  wire logic [7:0]  go,
	input  wire logic [3:0]  kind,
	input  wire logic [7:0]  bad_port,
	input  wire logic [7:0]  bad_cnt,
	output logic      [7:0]  rx_valid,
	output logic      [71:0] rx_sym
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] act = 8'h00;
	int         cnt = 0;
	logic       tog = 1'b0;
	logic [8:0] good;

	always_comb
	begin
		case (cnt[1:0])
			2'h0:    good = {kind[0], 8'hbc};
			2'h1:    good = {kind[1], 8'h4a};
			2'h2:    good = {kind[2], 8'hbc};
			default: good = {kind[3], 8'hb5};
		endcase
		rx_valid = act;
		for (int p = 0; p < 8; p++)
		begin
			if (!act[p])
				rx_sym[p*9+:9] = {9{tog}} ^ 9'h0a5;
			else if (bad_port[p] && cnt == int'(bad_cnt))
				rx_sym[p*9+:9] = good ^ 9'h001;
			else
				rx_sym[p*9+:9] = good;
		end
	end

	// run counter from the cycle after launch
	always @(posedge clk)
	begin
		tog <= ~tog;
		if (go != 8'h00)
		begin
			act <= go;
			cnt <= 0;
		end
		else if (act != 8'h00 && cnt == TEST_LEN - 1)
			act <= 8'h00;
		else if (act != 8'h00)
			cnt <= cnt + 1;
	end
endmodule

//--- verif/test_lst_status_ctrl.sv
// self-checking bench for the link self-test status block
`define CHK(nm, ex, gt) \
	begin \
		checks++; \
		if ((gt) !== (ex)) \
		begin \
			err_count++; \
			$display("wrong value %s exp %h got %h", nm, ex, gt); \
		end \
	end

module test_lst_status_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TLEN = 8;
	logic        clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [7:0]  rx_valid;
	logic [71:0] rx_sym;
	logic [7:0]  mismatch_out;
	logic [7:0]  go;
	logic [7:0]  bad_port;
	logic [7:0]  bad_cnt;
	int          err_count;
	int          checks;
	int          pulses [8];

	lst_status_ctrl #(.TEST_LEN(TLEN)) dut (.clk(clk), .ce(1'b1), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_sym(rx_sym), .mismatch_out(mismatch_out), .irq(irq));
	lst_link_partner #(.TEST_LEN(TLEN)) u_link (.clk(clk), .go(go), .kind(4'h5),
		.bad_port(bad_port), .bad_cnt(bad_cnt), .rx_valid(rx_valid), .rx_sym(rx_sym));

	always @(posedge clk)
		for (int p = 0; p < 8; p++)
			if (mismatch_out[p] === 1'b1)
				pulses[p]++;

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [7:0] g, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		go <= g;
		@(posedge clk);
		go <= 8'h00;
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [7:0] g);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, g, r, e);
		`CHK("write err", 1'b0, e)
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, 8'h00, r, e);
		`CHK(nm, x, r)
		`CHK("read err", xe, e)
	endtask

	task automatic t_reset;
		rd_chk("ctrl0", 12'he00, 32'h50000000, 1'b0);
		rd_chk("status", 12'he50, 32'h0, 1'b0);
		rd_chk("errflags", 12'he54, 32'h0, 1'b0);
		rd_chk("ctrl1", 12'he04, 32'h0, 1'b1);
		`CHK("irq", 1'b0, irq)
	endtask

	task automatic t_clean;
		wr(12'he84, 32'h000000fd, 8'h00);
		rd_chk("irq mask", 12'he84, 32'h000000fd, 1'b0);
		wr(12'he60, 32'h000000fd, 8'hfd);
		rd_chk("status run", 12'he50, 32'h0, 1'b0);
		repeat (TLEN + 4) @(posedge clk);
		rd_chk("status done", 12'he50, 32'h000000fd, 1'b0);
		`CHK("irq set", 1'b1, irq)
		wr(12'he50, 32'h000000ff, 8'h00);
		rd_chk("status ro", 12'he50, 32'h000000fd, 1'b0);
		wr(12'he80, 32'h0000ffff, 8'h00);
		repeat (2) @(posedge clk);
		`CHK("irq clr", 1'b0, irq)
		rd_chk("errflags", 12'he54, 32'h0, 1'b0);
	endtask

	task automatic t_error;
		wr(12'he08, 32'hd0000000, 8'h00);
		wr(12'he00, 32'h50000001, 8'h00);
		rd_chk("ctrl2", 12'he08, 32'hd0000000, 1'b0);
		rd_chk("ctrl0 open", 12'he00, 32'h50000001, 1'b0);
		bad_port <= 8'h81;
		bad_cnt <= 8'h05;
		pulses = '{default: 0};
		wr(12'he60, 32'h00000085, 8'h85);
		rd_chk("status relaunch", 12'he50, 32'h00000078, 1'b0);
		repeat (TLEN + 4) @(posedge clk);
		rd_chk("status done", 12'he50, 32'h000000fd, 1'b0);
		`CHK("pulses7", 1, pulses[7])
		`CHK("pulses2", 2, pulses[2])
		`CHK("pulses0", 0, pulses[0])
		`CHK("irq again", 1'b1, irq)
		rd_chk("irq status", 12'he80, 32'h00008485, 1'b0);
		rd_chk("start", 12'he60, 32'h00000085, 1'b0);
		rd_chk("errflags", 12'he54, 32'h00000084, 1'b0);
		wr(12'he54, 32'h00000000, 8'h00);
		rd_chk("err keep", 12'he54, 32'h00000084, 1'b0);
		wr(12'he54, 32'h00000004, 8'h00);
		rd_chk("err w1c", 12'he54, 32'h00000080, 1'b0);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		wrap_up;
	end

	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		go = 8'h00;
		bad_port = 8'h00;
		bad_cnt = 8'hff;
		err_count = 0;
		checks = 0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_clean;
		t_error;
		wrap_up;
	end
endmodule

//--- verilog/lst_port_engine.sv
// one port's self-test sequencer and symbol checker
module lst_port_engine #(
	parameter int TEST_LEN = lst_pkg::TEST_LEN
) (
	input  wire logic                     clk,
	input  wire logic                     ce,
	input  wire logic                     srst,
	input  wire logic                     start,
	input  wire logic                     open_mode,
	input  wire logic [3:0]               slot_kind,
	input  wire logic                     rx_valid,
	input  wire logic [lst_pkg::SYM_W-1:0] rx_sym,
	output logic                          running,
	output logic                          done,
	output logic                          mismatch
);

	localparam int CW = $clog2(TEST_LEN + 1);
	localparam logic [CW-1:0] LAST = CW'(TEST_LEN - 1);

	lst_pkg::lst_state_t state_reg;
	lst_pkg::lst_state_t state_next;
	logic [CW-1:0]       count_reg;
	logic                done_reg;
	logic                mism_reg;

	wire       last_cycle = (state_reg == lst_pkg::LST_RUN) && (count_reg == LAST);
	wire [1:0] slot       = count_reg[1:0];
	wire       exp_kind   = slot_kind[slot];
	wire [8:0] exp_sym    = {exp_kind, lst_pkg::lst_fixed_byte(slot)};
	// open mode checks only the character kind of each slot
	wire       sym_bad    = open_mode ? (rx_sym[8] != exp_kind) : (rx_sym != exp_sym);
	wire       mism_next  = (state_reg == lst_pkg::LST_RUN) && rx_valid && sym_bad && !start;

	always_comb
	begin
		case (state_reg)
			lst_pkg::LST_IDLE: state_next = start ? lst_pkg::LST_RUN : lst_pkg::LST_IDLE;
			lst_pkg::LST_RUN:  state_next = (last_cycle && !start) ? lst_pkg::LST_IDLE
			                                                       : lst_pkg::LST_RUN;
			default:           state_next = lst_pkg::LST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= lst_pkg::LST_IDLE;
			count_reg <= '0;
			done_reg  <= 1'b0;
			mism_reg  <= 1'b0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			count_reg <= (start || last_cycle) ? '0 : count_reg + CW'(1);
			done_reg  <= last_cycle && !start;
			mism_reg  <= mism_next;
		end
	end

	assign running  = (state_reg == lst_pkg::LST_RUN);
	assign done     = done_reg;
	assign mismatch = mism_reg;

endmodule

//--- verilog/lst_status_ctrl.sv
// link self-test status, error flags and per-port control over apb
//
// Contract
// - a one written to a port's start bit launches its test; all ports in one write start together.
// - one read-only done bit per port 7..2 and 0 at matching positions, bit 1 reads zero.
// - a done bit reads zero after reset, before the first start and while the test runs.
// - a done bit is set when the port's test finishes and holds until the next start.
// - hardware clears a port's done bit as its start bit is asserted.
// - one mismatch flag per port 7..2 and 0 at matching positions, reset zero, cleared by software.
// - each port's control register holds what fixed and open pattern modes need.
// - control reset values let the checker run over the full link without programming.
// - control bit 31, reset zero, marks slot 3 as control when set and data when clear.
//
// Added by the designer: the APB register port.
module lst_status_ctrl #(
	parameter int TEST_LEN = lst_pkg::TEST_LEN
) (
	input  wire logic                        clk,
	input  wire logic                        ce,
	input  wire logic                        srst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [lst_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [7:0]                  rx_valid,
	input  wire logic [8*lst_pkg::SYM_W-1:0] rx_sym,
	output logic      [7:0]                  mismatch_out,
	output logic                             irq
);

	// byte address of a register index
	function automatic logic [lst_pkg::ADDR_W-1:0] reg_addr(input logic [9:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction

	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [7:0]  start_reg;
	logic [7:0]  done_flag_reg;
	logic [7:0]  done_flag_next;
	logic [7:0]  err_reg;
	logic [7:0]  err_next;
	logic [15:0] ists_reg;
	logic [15:0] ists_next;
	logic [15:0] imsk_reg;
	logic [7:0]  mism_out_reg;
	logic        irq_reg;
	logic [3:0]  kind_reg [lst_pkg::NPORT];
	logic        mode_reg [lst_pkg::NPORT];

	logic [7:0]  running;
	logic [7:0]  done_evt;
	logic [7:0]  mism_evt;

	// address decode
	wire       setup_phase = psel && !penable;
	wire       access_edge = psel && penable && pready_reg;
	wire       wr_edge     = access_edge && pwrite;
	wire       aligned     = (paddr[1:0] == 2'b00);
	wire [2:0] ctrl_port   = paddr[4:2];
	wire [lst_pkg::ADDR_W-1:0] ctrl_base = reg_addr(lst_pkg::CTRL_IDX);
	wire       hit_ctrl    = aligned && (paddr[lst_pkg::ADDR_W-1:5]
	                         == ctrl_base[lst_pkg::ADDR_W-1:5])
	                         && lst_pkg::PORT_MASK[ctrl_port];
	wire       hit_stat    = paddr == reg_addr(lst_pkg::STAT_IDX);
	wire       hit_err     = paddr == reg_addr(lst_pkg::ERR_IDX);
	wire       hit_start   = paddr == reg_addr(lst_pkg::START_IDX);
	wire       hit_ists    = paddr == reg_addr(lst_pkg::ISTS_IDX);
	wire       hit_imsk    = paddr == reg_addr(lst_pkg::IMSK_IDX);
	wire       mapped      = hit_ctrl || hit_stat || hit_err || hit_start
	                         || hit_ists || hit_imsk;

	// write strobes per register and byte lane
	wire       wr_lane0    = wr_edge && pstrb[0];
	wire       wr_lane1    = wr_edge && pstrb[1];
	wire       wr_lane3    = wr_edge && pstrb[3];
	wire       wr_start    = wr_lane0 && hit_start;
	wire       wr_err      = wr_lane0 && hit_err;
	wire       wr_ctrl_lo  = wr_lane0 && hit_ctrl;
	wire       wr_ctrl_hi  = wr_lane3 && hit_ctrl;
	wire [15:0] ists_clr   = {wr_lane1 && hit_ists ? pwdata[15:8] : 8'h00,
	                          wr_lane0 && hit_ists ? pwdata[7:0] : 8'h00};

	wire [7:0] launch      = wr_start ? (pwdata[7:0] & lst_pkg::PORT_MASK) : 8'h00;

	// read mux
	wire [31:0] rd_ctrl    = {kind_reg[ctrl_port], 27'h0, mode_reg[ctrl_port]};
	wire [31:0] rd_data    = hit_ctrl  ? rd_ctrl :
	                         hit_stat  ? {24'h0, done_flag_reg} :
	                         hit_err   ? {24'h0, err_reg} :
	                         hit_start ? {24'h0, start_reg} :
	                         hit_ists  ? {16'h0, ists_reg} :
	                         hit_imsk  ? {16'h0, imsk_reg} : 32'h0;

	// per-port test engines; port 1 is absent
	genvar p;
	generate
		for (p = 0; p < lst_pkg::NPORT; p++)
		begin : g_port
			if (lst_pkg::PORT_MASK[p])
			begin : g_on
				lst_port_engine #(
					.TEST_LEN (TEST_LEN)
				) u_engine (
					.clk       (clk),
					.ce        (ce),
					.srst      (srst),
					.start     (launch[p]),
					.open_mode (mode_reg[p]),
					.slot_kind (kind_reg[p]),
					.rx_valid  (rx_valid[p]),
					.rx_sym    (rx_sym[p*lst_pkg::SYM_W +: lst_pkg::SYM_W]),
					.running   (running[p]),
					.done      (done_evt[p]),
					.mismatch  (mism_evt[p])
				);
			end
			else
			begin : g_off
				assign running[p]  = 1'b0;
				assign done_evt[p] = 1'b0;
				assign mism_evt[p] = 1'b0;
			end
		end
	endgenerate

	// done sets on finish, start clears it
	assign done_flag_next = (done_flag_reg | done_evt) & ~launch & lst_pkg::PORT_MASK;
	// new mismatch wins over write-one clear
	wire [7:0] err_wclr   = wr_err ? pwdata[7:0] : 8'h00;
	assign err_next       = ((err_reg & ~err_wclr) | mism_evt) & lst_pkg::PORT_MASK;
	assign ists_next      = (ists_reg & ~ists_clr) | {mism_evt, done_evt};

	// apb answer: one wait state, data taken in setup
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else if (ce)
		begin
			pready_reg  <= setup_phase;
			prdata_reg  <= (setup_phase && !pwrite) ? rd_data : 32'h0;
			pslverr_reg <= setup_phase && !mapped;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			done_flag_reg <= lst_pkg::STAT_RST;
			err_reg       <= lst_pkg::ERR_RST;
			start_reg     <= lst_pkg::START_RST;
		end
		else if (ce)
		begin
			done_flag_reg <= done_flag_next;
			err_reg       <= err_next;
			if (wr_start)
				start_reg <= pwdata[7:0] & lst_pkg::PORT_MASK;
		end
	end

	// interrupt status, mask, level output
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ists_reg     <= lst_pkg::ISTS_RST;
			imsk_reg     <= lst_pkg::IMSK_RST;
			irq_reg      <= 1'b0;
			mism_out_reg <= 8'h00;
		end
		else if (ce)
		begin
			ists_reg <= ists_next;
			if (wr_lane0 && hit_imsk)
				imsk_reg[7:0] <= pwdata[7:0];
			if (wr_lane1 && hit_imsk)
				imsk_reg[15:8] <= pwdata[15:8];
			irq_reg      <= |(ists_reg & imsk_reg);
			mism_out_reg <= mism_evt;
		end
	end

	generate
		for (p = 0; p < lst_pkg::NPORT; p++)
		begin : g_ctrl
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					kind_reg[p] <= lst_pkg::KIND_RST;
					mode_reg[p] <= lst_pkg::MODE_RST;
				end
				else if (ce)
				begin
					if (wr_ctrl_hi && ctrl_port == 3'(p))
						kind_reg[p] <= pwdata[lst_pkg::KIND_LSB +: 4];
					if (wr_ctrl_lo && ctrl_port == 3'(p))
						mode_reg[p] <= pwdata[lst_pkg::MODE_BIT];
				end
			end
		end
	endgenerate

	assign prdata       = prdata_reg;
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;
	assign mismatch_out = mism_out_reg;
	assign irq          = irq_reg;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || !ce);

	chk_launch_all_run: assert property (
		|launch |=> (running & $past(launch)) == $past(launch))
		else $error("launched port not running");

	chk_start_readback: assert property (
		wr_start |=> start_reg == $past(pwdata[7:0] & lst_pkg::PORT_MASK))
		else $error("start register wrong");

	chk_launch_clears_done: assert property (
		|launch |=> (done_flag_reg & $past(launch)) == 8'h00)
		else $error("done bit not cleared by start");

	chk_running_not_done: assert property (
		(done_flag_reg & running) == 8'h00)
		else $error("done bit set while running");

	chk_done_reset: assert property (disable iff (!ce)
		srst |=> done_flag_reg == lst_pkg::STAT_RST)
		else $error("done bits not cleared by reset");

	chk_finish_sets_done: assert property (
		|(done_evt & ~launch) |=> (done_flag_reg & $past(done_evt & ~launch))
		== $past(done_evt & ~launch))
		else $error("done bit not set on finish");

	chk_done_only_finish: assert property (
		##1 (done_flag_reg & ~$past(done_flag_reg) & ~$past(done_evt)) == 8'h00)
		else $error("done bit set without finish");

	chk_done_holds: assert property (
		##1 ($past(done_flag_reg) & ~$past(launch) & ~done_flag_reg) == 8'h00)
		else $error("done bit dropped without start");

	chk_reserved_zero: assert property (
		!done_flag_reg[1] && !err_reg[1] && !running[1])
		else $error("port 1 bit set");

	chk_stat_read: assert property (
		setup_phase && !pwrite && hit_stat |=> prdata == {24'h0, $past(done_flag_reg)})
		else $error("status read wrong");

	chk_err_reset: assert property (disable iff (!ce)
		srst |=> err_reg == lst_pkg::ERR_RST)
		else $error("mismatch flags not cleared by reset");

	chk_err_set_wins: assert property (
		|mism_evt |=> (err_reg & $past(mism_evt)) == $past(mism_evt))
		else $error("mismatch flag lost");

	chk_err_only_mismatch: assert property (
		##1 (err_reg & ~$past(err_reg) & ~$past(mism_evt)) == 8'h00)
		else $error("mismatch flag set without mismatch");

	// flag drops only on write one
	chk_err_hold: assert property (
		##1 ($past(err_reg) & ~err_reg & ~$past(err_wclr)) == 8'h00)
		else $error("mismatch flag dropped without write");

	chk_err_w1c: assert property (
		wr_err && (pwdata[7:0] & ~mism_evt) != 8'h00 |=>
		(err_reg & $past(pwdata[7:0] & ~mism_evt)) == 8'h00)
		else $error("mismatch flag not cleared");

	chk_mism_pulse: assert property (
		##1 mismatch_out == $past(mism_evt))
		else $error("mismatch pulse wrong");

	chk_ctrl_read: assert property (
		setup_phase && !pwrite && hit_ctrl |=>
		prdata[27:1] == 27'h0 && prdata[31:28] == $past(kind_reg[ctrl_port]))
		else $error("control read wrong");

	chk_ctrl_write: assert property (
		wr_ctrl_hi |=> kind_reg[$past(ctrl_port)] == $past(pwdata[lst_pkg::KIND_LSB +: 4]))
		else $error("control write lost");

	chk_mode_reset: assert property (disable iff (!ce)
		srst |=> !mode_reg[0] && !mode_reg[7])
		else $error("mode reset value wrong");

	chk_slot3_reset: assert property (disable iff (!ce)
		srst |=> kind_reg[0] == lst_pkg::KIND_RST && !kind_reg[7][3])
		else $error("control reset value wrong");

	// irq follows masked status
	chk_irq_level: assert property (
		##1 irq == |($past(ists_reg & imsk_reg)))
		else $error("irq level wrong");

	// apb answers in one wait state
	chk_apb_one_wait: assert property (
		setup_phase |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	// unmapped access refused
	chk_slverr_unmapped: assert property (
		setup_phase && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");

	cov_done_evt: cover property (|done_evt);
	cov_mismatch: cover property (|mism_evt ##1 |err_reg);
	cov_irq:      cover property (irq);
	cov_multi:    cover property ($countones(launch) > 1);
	cov_w1c:      cover property (|err_wclr && |err_reg);

endmodule
